// >>> inc/sdd_pkg.sv
// package for the supply droop detector and ram validity flag block
package sdd_pkg;
  localparam int ADDR_W = 32;
  localparam logic [31:0] CTRL_ADDR = 32'hfffff890;
  localparam logic [31:0] LEVEL_ADDR = 32'hfffff891;
  localparam logic [31:0] RAMST_ADDR = 32'hfffff892;
  localparam logic [31:0] EMU_ADDR = 32'hfffff9fe;
  localparam logic [31:0] PROTECT_ADDR = 32'hfffff800;
  localparam logic [7:0] PROTECT_KEY = 8'ha5;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam int CTRL_EN_BIT = 7;
  localparam int CTRL_MODE_BIT = 1;
  localparam int CTRL_FLAG_BIT = 0;
  localparam int LEVEL_BIT = 0;
  localparam int RAM_INVALID_FLAG_BIT = 0;
  localparam int EMU_FORCE_BIT = 2;
  localparam logic RAM_INVALID_FLAG_RESET = 1'b1;
  localparam real SETTLE_MS = 0.1;
  localparam real CLOCK_MHZ = 125.0;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sdd_bus_t;
  typedef struct packed {
    logic watchdog;
    logic clockMon;
    logic accessReset;
    logic detector;
  } sdd_rst_src_t;
endpackage

// >>> rtl/sdd_top.sv
// supply droop detector control and ram validity flag logic
// What this block does
// - level select bit 0, low level when 1
// - ram status resets to 01h
// - ram invalid flag one means invalid
// - ram status written only by protected sequence
// - ram flag set by listed events
// - ram flag cleared only by protected zero
// - emulation force bit 2, emulation mode only
// - force bit sets flag in emulation mode, never self clears
// - force bit high blocks flag clearing in emulation mode only
// - droop gives interrupt or reset by mode
// - mode one locks control and level registers
// - reset held while supply below level
// - detector reset sets reset cause flag
// - clearing enable stops detection
// - retention comparator low sets ram flag
// - control register enable, mode, flag layout
// - flag shows below level while enabled
// - flag drives interrupt when enabled, mode zero
// - enable and mode survive detector reset only
//
// The implementer's own choice: the strobed register port.
`timescale 1ns/100ps
module sdd_top
  import sdd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire sdd_bus_t bus,
  output logic [7:0] rdata,
  input wire logic emuMode,
  input wire logic cmpBelowHigh,
  input wire logic cmpBelowLow,
  input wire logic cmpBelowRetention,
  input wire sdd_rst_src_t otherReset,
  input wire logic setRamByInstr,
  output logic droop_irq,
  output logic droopReset,
  output logic droop_reset_cause_flag
);
  logic enable_reg;
  logic mode_reg;
  logic level_reg;
  logic ram_invalid_flag_reg;
  logic force_reg;
  logic unlock_reg;
  logic cause_reg;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic belowSel;
  logic flagNow;
  logic lockHit;
  logic nonDetReset;
  logic protWr;

  function automatic logic hit(input sdd_bus_t b, input logic [31:0] a);
    return b.wr && (b.addr == a);
  endfunction

  // comparator synchroniser, first stage feeds only the second
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
    end else begin
      sync1_reg <= {cmpBelowRetention, cmpBelowLow, cmpBelowHigh};
      sync2_reg <= sync1_reg;
    end
  end

  assign belowSel = level_reg ? sync2_reg[1] : sync2_reg[0];
  assign flagNow = enable_reg && belowSel;
  assign lockHit = mode_reg;
  assign nonDetReset = otherReset.watchdog || otherReset.clockMon ||
                       otherReset.accessReset;
  assign protWr = unlock_reg && hit(bus, RAMST_ADDR);

  // protect key arms exactly the next bus write
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      unlock_reg <= 1'b0;
    end else if (bus.wr) begin
      unlock_reg <= (bus.addr == PROTECT_ADDR) && (bus.wdata == PROTECT_KEY);
    end
  end

  // control and level, locked in reset mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_reg <= 1'b0;
      mode_reg <= 1'b0;
      level_reg <= 1'b0;
    end else if (nonDetReset) begin
      enable_reg <= 1'b0;
      mode_reg <= 1'b0;
      level_reg <= 1'b0;
    end else if (!lockHit) begin
      if (hit(bus, CTRL_ADDR)) begin
        enable_reg <= bus.wdata[CTRL_EN_BIT];
        mode_reg <= bus.wdata[CTRL_MODE_BIT];
      end
      if (hit(bus, LEVEL_ADDR)) begin
        level_reg <= bus.wdata[LEVEL_BIT];
      end
    end
  end

  // ram invalid flag, set wins over clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ram_invalid_flag_reg <= RAM_INVALID_FLAG_RESET;
    end else if (sync2_reg[2] || setRamByInstr || nonDetReset ||
                 (force_reg && emuMode) || droopReset) begin
      ram_invalid_flag_reg <= 1'b1;
    end else if (protWr && !bus.wdata[RAM_INVALID_FLAG_BIT]) begin
      ram_invalid_flag_reg <= 1'b0;
    end else if (protWr) begin
      ram_invalid_flag_reg <= 1'b1;
    end
  end

  // emulation force bit, only writable in emulation mode
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      force_reg <= 1'b0;
    end else if (emuMode && hit(bus, EMU_ADDR)) begin
      force_reg <= bus.wdata[EMU_FORCE_BIT];
    end
  end

  // reset cause flag, cleared by other reset sources
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cause_reg <= 1'b0;
    end else if (droopReset) begin
      cause_reg <= 1'b1;
    end else if (nonDetReset) begin
      cause_reg <= 1'b0;
    end
  end

  assign droop_irq = flagNow && !mode_reg;
  assign droopReset = flagNow && mode_reg;
  assign droop_reset_cause_flag = cause_reg;

  // read data one cycle after strobe, reserved bits zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= ZERO_BYTE;
    end else begin
      rdata <= ZERO_BYTE;
      if (bus.rd) begin
        case (bus.addr)
          CTRL_ADDR: begin
            rdata[CTRL_EN_BIT] <= enable_reg;
            rdata[CTRL_MODE_BIT] <= mode_reg;
            rdata[CTRL_FLAG_BIT] <= flagNow;
          end
          LEVEL_ADDR: rdata[LEVEL_BIT] <= level_reg;
          RAMST_ADDR: rdata[RAM_INVALID_FLAG_BIT] <= ram_invalid_flag_reg;
          EMU_ADDR: rdata[EMU_FORCE_BIT] <= force_reg;
          default: rdata <= ZERO_BYTE;
        endcase
      end
    end
  end

  lock_holds_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    mode_reg && !nonDetReset |=> $stable(level_reg) && mode_reg)
    else $error("locked registers changed");

  force_blocks_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    force_reg && emuMode |=> ram_invalid_flag_reg)
    else $error("flag clear while forced");

  plain_clear_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    ram_invalid_flag_reg && !protWr |=> ram_invalid_flag_reg)
    else $error("flag cleared without sequence");

  irq_mode_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    droop_irq |-> enable_reg && !mode_reg)
    else $error("irq outside interrupt mode");

  reset_held_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    mode_reg && enable_reg && belowSel |-> droopReset)
    else $error("droop reset not held");

  cause_set_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    droopReset |=> droop_reset_cause_flag)
    else $error("cause flag not set");

  retention_set_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    cmpBelowRetention ##2 1 |=> ram_invalid_flag_reg)
    else $error("retention low missed");

  disabled_quiet_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !enable_reg |-> !droop_irq && !droopReset)
    else $error("droop event while disabled");

  sync_pipe_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    sync2_reg == $past(sync1_reg))
    else $error("second sync stage wrong");

  sync_first_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    sync1_reg == $past({cmpBelowRetention, cmpBelowLow, cmpBelowHigh}))
    else $error("first sync stage wrong");

  level_write_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !lockHit && !nonDetReset && hit(bus, LEVEL_ADDR) |=>
    level_reg == $past(bus.wdata[LEVEL_BIT]))
    else $error("level write lost");

  ctrl_en_write_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !lockHit && !nonDetReset && hit(bus, CTRL_ADDR) |=>
    enable_reg == $past(bus.wdata[CTRL_EN_BIT]))
    else $error("enable write lost");

  ctrl_mode_write_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !lockHit && !nonDetReset && hit(bus, CTRL_ADDR) |=>
    mode_reg == $past(bus.wdata[CTRL_MODE_BIT]))
    else $error("mode write lost");

  other_reset_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    nonDetReset |=> !enable_reg && !mode_reg && !level_reg)
    else $error("other reset kept control");

  other_ram_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    nonDetReset |=> ram_invalid_flag_reg)
    else $error("other reset left flag clear");

  lock_ctrl_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    lockHit && !nonDetReset |=> $stable(enable_reg))
    else $error("locked enable changed");

  key_needed_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !unlock_reg |-> !protWr)
    else $error("protected write without key");

  ram_clear_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    $fell(ram_invalid_flag_reg) |-> $past(protWr && !bus.wdata[RAM_INVALID_FLAG_BIT]))
    else $error("flag cleared without zero write");

  instr_set_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    setRamByInstr |=> ram_invalid_flag_reg)
    else $error("instruction set missed");

  force_normal_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !emuMode && hit(bus, EMU_ADDR) |=> $stable(force_reg))
    else $error("force written in normal mode");

  force_keep_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    force_reg && !hit(bus, EMU_ADDR) |=> force_reg)
    else $error("force bit cleared itself");

  force_clear_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    force_reg && emuMode && protWr |=> ram_invalid_flag_reg)
    else $error("clear beat the force bit");

  cause_hold_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    droop_reset_cause_flag && !nonDetReset |=> droop_reset_cause_flag)
    else $error("cause flag lost");

  irq_follow_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    enable_reg && !mode_reg && belowSel |-> droop_irq)
    else $error("irq missing");

  below_quiet_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !belowSel |-> !droop_irq && !droopReset)
    else $error("droop event above level");

  irq_reset_excl_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !(droop_irq && droopReset))
    else $error("irq and reset together");

  rdata_idle_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !bus.rd |=> rdata == ZERO_BYTE)
    else $error("read data outside read");

  ram_read_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    bus.rd && bus.addr == RAMST_ADDR |=> rdata[RAM_INVALID_FLAG_BIT] == $past(ram_invalid_flag_reg))
    else $error("ram flag read wrong");

  level_read_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    bus.rd && bus.addr == LEVEL_ADDR |=>
    rdata[LEVEL_BIT] == $past(level_reg))
    else $error("level read wrong");

  emu_read_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    bus.rd && bus.addr == EMU_ADDR |=>
    rdata[EMU_FORCE_BIT] == $past(force_reg))
    else $error("force read wrong");

  ctrl_read_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    bus.rd && bus.addr == CTRL_ADDR |=>
    rdata[CTRL_FLAG_BIT] == $past(flagNow))
    else $error("below flag read wrong");

  reset_mode_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    droopReset |-> mode_reg && enable_reg)
    else $error("droop reset outside reset mode");

  prot_set_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    protWr && bus.wdata[RAM_INVALID_FLAG_BIT] |=> ram_invalid_flag_reg)
    else $error("protected set missed");

  level_hold_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !hit(bus, LEVEL_ADDR) && !nonDetReset |=> $stable(level_reg))
    else $error("level changed unasked");

  en_hold_a: assert property (
    @(posedge clock) disable iff (!rst_n)
    !hit(bus, CTRL_ADDR) && !nonDetReset |=> $stable(enable_reg))
    else $error("enable changed unasked");
endmodule

// >>> tb/sdd_supply_model.sv
// comparator model of the supply seen by the detector
`timescale 1ns/100ps
module sdd_supply_model #(
  parameter logic [7:0] RET_LEVEL = 8'h14
) (
  input wire logic [7:0] supply,
  output logic cmpBelowHigh,
  output logic cmpBelowLow,
  output logic cmpBelowRetention
);
  // supply in tenths of a volt
  assign cmpBelowHigh = supply < 8'h2c;
  assign cmpBelowLow = supply < 8'h2a;
  assign cmpBelowRetention = supply < RET_LEVEL;
endmodule

// >>> tb/testbench.sv
// bench for the droop detector and ram flag block
`timescale 1ns/100ps
module testbench import sdd_pkg::*;;
  logic clock = 0, rst_n = 0, emuMode = 0, setRam = 0;
  logic [7:0] rdata, supply = 8'h32, lf = 8'h3b;
  logic cbh, cbl, cbr, droop_irq, droopReset, cause;
  sdd_bus_t b = '0;
  sdd_rst_src_t oth = '0;
  int errors = 0, n_checks = 0, lvl;
  sdd_top u_dut(.clock(clock), .rst_n(rst_n), .bus(b), .rdata(rdata),
    .emuMode(emuMode), .cmpBelowHigh(cbh), .cmpBelowLow(cbl),
    .cmpBelowRetention(cbr), .otherReset(oth), .setRamByInstr(setRam),
    .droop_irq(droop_irq), .droopReset(droopReset),
    .droop_reset_cause_flag(cause));
  sdd_supply_model u_sup(.supply(supply), .cmpBelowHigh(cbh),
    .cmpBelowLow(cbl), .cmpBelowRetention(cbr));
  initial forever #4 clock = ~clock;
  task automatic chk(input string n, input logic [7:0] e, s);
    n_checks++;
    if (s !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic w(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    b <= '{a, d, 1'b1, 1'b0};
    w(1);
    b.wr <= 1'b0;
    w(1);
  endtask
  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    b <= '{a, 8'h00, 1'b0, 1'b1};
    w(1);
    b.rd <= 1'b0;
    #1 chk("rdata", e, rdata);
    w(1);
  endtask
  task automatic pw(input logic [7:0] d);
    wr(PROTECT_ADDR, PROTECT_KEY);
    wr(RAMST_ADDR, d);
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #300000;
    errors++;
    test_done();
  end
  initial begin
    w(2);
    rst_n <= 1;
    w(1);
    rd(CTRL_ADDR, 0);
    rd(LEVEL_ADDR, 0);
    rd(RAMST_ADDR, 1);
    rd(EMU_ADDR, 0);
    rd(32'hfffff893, 0);
    repeat (4) begin
      lf = nxt(lf);
      lvl = lf[0];
      wr(LEVEL_ADDR, lf);
      rd(LEVEL_ADDR, lvl);
    end
    wr(RAMST_ADDR, 0);
    rd(RAMST_ADDR, 1);
    pw(0);
    rd(RAMST_ADDR, 0);
    setRam <= 1;
    w(1);
    setRam <= 0;
    rd(RAMST_ADDR, 1);
    for (int i = 0; i < 3; i++) begin
      pw(0);
      wr(LEVEL_ADDR, 1);
      oth <= 4'h8 >> i;
      w(1);
      oth <= '0;
      rd(RAMST_ADDR, 1);
      rd(LEVEL_ADDR, 0);
    end
    pw(0);
    supply <= 8'h0a;
    w(4);
    supply <= 8'h32;
    rd(RAMST_ADDR, 1);
    $display("ram flag tests done");
    wr(EMU_ADDR, 8'h04);
    rd(EMU_ADDR, 0);
    emuMode <= 1;
    pw(0);
    wr(EMU_ADDR, 8'hff);
    rd(EMU_ADDR, 8'h04);
    pw(0);
    rd(RAMST_ADDR, 1);
    emuMode <= 0;
    pw(0);
    rd(RAMST_ADDR, 0);
    emuMode <= 1;
    wr(EMU_ADDR, 0);
    pw(0);
    rd(RAMST_ADDR, 0);
    emuMode <= 0;
    $display("emulation tests done");
    wr(CTRL_ADDR, 8'h80);
    supply <= 8'h2b;
    w(4);
    chk("droop_irq", 1, droop_irq);
    rd(CTRL_ADDR, 8'h81);
    wr(LEVEL_ADDR, 1);
    w(4);
    chk("droop_irq", 0, droop_irq);
    wr(CTRL_ADDR, 0);
    supply <= 8'h28;
    w(4);
    chk("droop_irq", 0, droop_irq);
    rd(CTRL_ADDR, 0);
    supply <= 8'h32;
    wr(CTRL_ADDR, 8'h80);
    w(12500);
    rd(CTRL_ADDR, 8'h80);
    wr(CTRL_ADDR, 8'h82);
    wr(LEVEL_ADDR, 0);
    rd(LEVEL_ADDR, 1);
    wr(CTRL_ADDR, 0);
    rd(CTRL_ADDR, 8'h82);
    supply <= 8'h29;
    w(4);
    chk("droopReset", 1, droopReset);
    chk("droop_irq", 0, droop_irq);
    chk("cause", 1, cause);
    supply <= 8'h32;
    w(4);
    chk("droopReset", 0, droopReset);
    oth <= 4'h8;
    w(1);
    oth <= '0;
    rd(CTRL_ADDR, 0);
    $display("detector tests done");
    test_done();
  end
endmodule
